// ### mdir_defines.vh
// register offsets, field positions and detect codes of the interrupt router
`ifndef MDIR_DEFINES_VH
`define MDIR_DEFINES_VH
// ****************************************
// word indices (byte address = 4 * index)
// ****************************************
`define MDIR_IDX_SRC_LEVEL 5'h00
`define MDIR_IDX_SRC_NONLATCH 5'h01
`define MDIR_IDX_SRC_DETECT_LO 5'h02
`define MDIR_IDX_SRC_DETECT_HI 5'h03
`define MDIR_IDX_SRC_INJECT 5'h04
`define MDIR_IDX_SRC_LATCH 5'h05
`define MDIR_IDX_SRC_ENABLE 5'h06
`define MDIR_IDX_SRC_ENA_CLR 5'h07
`define MDIR_IDX_SRC_ENA_SET 5'h08
`define MDIR_IDX_SRC_PENDING 5'h09
`define MDIR_IDX_ROUTE0 5'h0a
`define MDIR_IDX_TPEND0 5'h0e
`define MDIR_IDX_MOD_POL 5'h12
`define MDIR_IDX_MOD_LEVEL 5'h13
`define MDIR_IDX_MOD_NONLATCH 5'h14
`define MDIR_IDX_MOD_DETECT_LO 5'h15
`define MDIR_IDX_MOD_DETECT_HI 5'h16
`define MDIR_IDX_MOD_LATCH 5'h17
`define MDIR_IDX_MOD_ENABLE 5'h18
`define MDIR_IDX_MOD_PENDING 5'h19
`define MDIR_IDX_EXT_IN_POL 5'h1a
`define MDIR_IDX_EXT_OUT_POL 5'h1b
`define MDIR_IDX_EXT_OUT_DRV 5'h1c
// ****************************************
// source bit positions and destination indices
// ****************************************
`define MDIR_SRC_PORT_MODULE 0
`define MDIR_SRC_EXT_IN0 1
`define MDIR_SRC_EXT_IN1 2
`define MDIR_SRC_PCIE 23
`define MDIR_DST_CORE0 0
`define MDIR_DST_CORE1 1
`define MDIR_DST_EXT0 2
`define MDIR_DST_EXT1 3
// ****************************************
// detect kinds and misc
// ****************************************
`define MDIR_DET_LEVEL 2'h0
`define MDIR_DET_CHANGE 2'h1
`define MDIR_DET_FALL 2'h2
`define MDIR_DET_RISE 2'h3
`define MDIR_UNMAPPED_DATA 32'h00000000
`endif

// ### mdir_router.v
// multi-destination interrupt router with avalon-mm register slave
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`include "mdir_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module mdir_router #(
  parameter NSRC = 24,
  parameter NMOD = 11
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // avalon-mm slave
  input wire [6:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // interrupt sources
  input wire [NMOD-1:0] port_module_irq,
  input wire external_input_zero,
  input wire external_input_one,
  input wire [NSRC-1:3] block_irq,
  // destinations
  output reg core_line_zero,
  output reg core_line_one,
  output reg external_output_zero,
  output reg external_output_zero_oe,
  output reg external_output_one,
  output reg external_output_one_oe
);
  // ****************************************
  // input synchronisers
  // ****************************************
  reg [NMOD+1:0] sync1_q;
  reg [NMOD+1:0] sync2_q;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= {(NMOD+2){1'b0}};
      sync2_q <= {(NMOD+2){1'b0}};
    end else begin
      sync1_q <= {external_input_one, external_input_zero, port_module_irq};
      sync2_q <= sync1_q;
    end
  end
  // ****************************************
  // registers
  // ****************************************
  reg [NSRC-1:0] src_nonlatch_q, source_debug_inject_q, src_latch_q;
  reg [NSRC-1:0] source_enable_mask_q, src_prev_q;
  reg [2*NSRC-1:0] src_detect_q;
  reg [NSRC-1:0] route_q [0:3];
  reg [NMOD-1:0] mod_pol_q, mod_nonlatch_q, mod_latch_q, mod_enable_q;
  reg [NMOD-1:0] mod_prev_q;
  reg [2*NMOD-1:0] mod_detect_q;
  reg [1:0] ext_in_pol_q, ext_out_pol_q, ext_out_drv_q;
  // ****************************************
  // module level hierarchy
  // ****************************************
  wire [NMOD-1:0] module_level_view = sync2_q[NMOD-1:0] ^ mod_pol_q;
  wire [NMOD-1:0] mod_event, mod_eff, module_pending_view;
  // ****************************************
  // source level
  // ****************************************
  wire [NSRC-1:0] source_level_view;
  wire [NSRC-1:0] src_event, src_eff, source_pending_view;
  wire [1:0] ext_in = sync2_q[NMOD+1:NMOD] ^ ext_in_pol_q;
  assign source_level_view = {block_irq, ext_in, |module_pending_view};
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_src
      wire [1:0] k = src_detect_q[2*gi+1:2*gi];
      wire r = source_level_view[gi];
      wire p = src_prev_q[gi];
      assign src_event[gi] = (k == `MDIR_DET_LEVEL) ? r :
        (k == `MDIR_DET_CHANGE) ? (r ^ p) :
        (k == `MDIR_DET_FALL) ? (p & ~r) : (r & ~p);
      assign src_eff[gi] = src_nonlatch_q[gi] ? r : src_latch_q[gi];
    end
    for (gi = 0; gi < NMOD; gi = gi + 1) begin : g_mod
      wire [1:0] k = mod_detect_q[2*gi+1:2*gi];
      wire r = module_level_view[gi];
      wire p = mod_prev_q[gi];
      assign mod_event[gi] = (k == `MDIR_DET_LEVEL) ? r :
        (k == `MDIR_DET_CHANGE) ? (r ^ p) :
        (k == `MDIR_DET_FALL) ? (p & ~r) : (r & ~p);
      assign mod_eff[gi] = mod_nonlatch_q[gi] ? r : mod_latch_q[gi];
    end
  endgenerate
  assign module_pending_view = mod_eff & mod_enable_q;
  assign source_pending_view = src_eff & source_enable_mask_q;
  wire [NSRC-1:0] tpend0 = source_pending_view & route_q[0];
  wire [NSRC-1:0] tpend1 = source_pending_view & route_q[1];
  wire [NSRC-1:0] tpend2 = source_pending_view & route_q[2];
  wire [NSRC-1:0] tpend3 = source_pending_view & route_q[3];
  // ****************************************
  // bus decode
  // ****************************************
  wire [4:0] idx = avs_address[6:2];
  wire wr = avs_write & avs_waitrequest;
  wire rd = avs_read & avs_waitrequest;
  reg [31:0] wmask;
  always @* begin
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  end
  wire [31:0] wd = avs_writedata & wmask;
  reg [31:0] rdata;
  always @* begin
    rdata = `MDIR_UNMAPPED_DATA;
    if (idx == `MDIR_IDX_SRC_LEVEL) begin
      rdata[NSRC-1:0] = source_level_view;
    end else if (idx == `MDIR_IDX_SRC_NONLATCH) begin
      rdata[NSRC-1:0] = src_nonlatch_q;
    end else if (idx == `MDIR_IDX_SRC_DETECT_LO) begin
      rdata[31:0] = src_detect_q[31:0];
    end else if (idx == `MDIR_IDX_SRC_DETECT_HI) begin
      rdata[2*NSRC-33:0] = src_detect_q[2*NSRC-1:32];
    end else if (idx == `MDIR_IDX_SRC_INJECT) begin
      rdata[NSRC-1:0] = source_debug_inject_q;
    end else if (idx == `MDIR_IDX_SRC_LATCH) begin
      rdata[NSRC-1:0] = src_latch_q;
    end else if (idx == `MDIR_IDX_SRC_ENABLE) begin
      rdata[NSRC-1:0] = source_enable_mask_q;
    end else if (idx == `MDIR_IDX_SRC_PENDING) begin
      rdata[NSRC-1:0] = source_pending_view;
    end else if (idx >= `MDIR_IDX_ROUTE0 && idx < `MDIR_IDX_TPEND0) begin
      rdata[NSRC-1:0] = route_q[idx[1:0] - 2'h2];
    end else if (idx == `MDIR_IDX_TPEND0) begin
      rdata[NSRC-1:0] = tpend0;
    end else if (idx == `MDIR_IDX_TPEND0 + 5'h1) begin
      rdata[NSRC-1:0] = tpend1;
    end else if (idx == `MDIR_IDX_TPEND0 + 5'h2) begin
      rdata[NSRC-1:0] = tpend2;
    end else if (idx == `MDIR_IDX_TPEND0 + 5'h3) begin
      rdata[NSRC-1:0] = tpend3;
    end else if (idx == `MDIR_IDX_MOD_POL) begin
      rdata[NMOD-1:0] = mod_pol_q;
    end else if (idx == `MDIR_IDX_MOD_LEVEL) begin
      rdata[NMOD-1:0] = module_level_view;
    end else if (idx == `MDIR_IDX_MOD_NONLATCH) begin
      rdata[NMOD-1:0] = mod_nonlatch_q;
    end else if (idx == `MDIR_IDX_MOD_DETECT_LO) begin
      rdata[2*NMOD-1:0] = mod_detect_q;
    end else if (idx == `MDIR_IDX_MOD_LATCH) begin
      rdata[NMOD-1:0] = mod_latch_q;
    end else if (idx == `MDIR_IDX_MOD_ENABLE) begin
      rdata[NMOD-1:0] = mod_enable_q;
    end else if (idx == `MDIR_IDX_MOD_PENDING) begin
      rdata[NMOD-1:0] = module_pending_view;
    end else if (idx == `MDIR_IDX_EXT_IN_POL) begin
      rdata[1:0] = ext_in_pol_q;
    end else if (idx == `MDIR_IDX_EXT_OUT_POL) begin
      rdata[1:0] = ext_out_pol_q;
    end else if (idx == `MDIR_IDX_EXT_OUT_DRV) begin
      rdata[1:0] = ext_out_drv_q;
    end
  end
  wire [NSRC-1:0] wsrc = wd[NSRC-1:0];
  wire [NMOD-1:0] wmod = wd[NMOD-1:0];
  wire [NSRC-1:0] wmsk_s = wmask[NSRC-1:0];
  wire [NMOD-1:0] wmsk_m = wmask[NMOD-1:0];
  // ****************************************
  // bus handshake: one wait cycle per access
  // ****************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (rd) begin
        avs_readdata <= rdata;
      end
    end
  end
  // ****************************************
  // configuration and latch state
  // ****************************************
  wire wsel_inject = wr && idx == `MDIR_IDX_SRC_INJECT;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_nonlatch_q <= {NSRC{1'b0}};
      source_debug_inject_q <= {NSRC{1'b0}};
      src_latch_q <= {NSRC{1'b0}};
      source_enable_mask_q <= {NSRC{1'b0}};
      src_prev_q <= {NSRC{1'b0}};
      src_detect_q <= {(2*NSRC){1'b0}};
      route_q[0] <= {NSRC{1'b0}};
      route_q[1] <= {NSRC{1'b0}};
      route_q[2] <= {NSRC{1'b0}};
      route_q[3] <= {NSRC{1'b0}};
      mod_pol_q <= {NMOD{1'b0}};
      mod_nonlatch_q <= {NMOD{1'b0}};
      mod_latch_q <= {NMOD{1'b0}};
      mod_enable_q <= {NMOD{1'b0}};
      mod_prev_q <= {NMOD{1'b0}};
      mod_detect_q <= {(2*NMOD){1'b0}};
      ext_in_pol_q <= 2'h0;
      ext_out_pol_q <= 2'h0;
      ext_out_drv_q <= 2'h0;
    end else begin
      src_prev_q <= source_level_view;
      mod_prev_q <= module_level_view;
      source_debug_inject_q <= wsel_inject ? wsrc : {NSRC{1'b0}};
      // write one clears, any event sets, set wins
      src_latch_q <= (src_latch_q &
        ~((wr && idx == `MDIR_IDX_SRC_LATCH) ? wsrc : {NSRC{1'b0}}))
        | src_event | source_debug_inject_q;
      mod_latch_q <= (mod_latch_q &
        ~((wr && idx == `MDIR_IDX_MOD_LATCH) ? wmod : {NMOD{1'b0}}))
        | mod_event;
      if (wr) begin
        if (idx == `MDIR_IDX_SRC_NONLATCH) begin
          src_nonlatch_q <= (src_nonlatch_q & ~wmsk_s) | wsrc;
        end else if (idx == `MDIR_IDX_SRC_DETECT_LO) begin
          src_detect_q[31:0] <= (src_detect_q[31:0] & ~wmask) | wd;
        end else if (idx == `MDIR_IDX_SRC_DETECT_HI) begin
          src_detect_q[2*NSRC-1:32] <= wd[2*NSRC-33:0] |
            (src_detect_q[2*NSRC-1:32] & ~wmask[2*NSRC-33:0]);
        end else if (idx == `MDIR_IDX_SRC_ENABLE) begin
          source_enable_mask_q <= (source_enable_mask_q & ~wmsk_s) | wsrc;
        end else if (idx == `MDIR_IDX_SRC_ENA_CLR) begin
          source_enable_mask_q <= source_enable_mask_q & ~wsrc;
        end else if (idx == `MDIR_IDX_SRC_ENA_SET) begin
          source_enable_mask_q <= source_enable_mask_q | wsrc;
        end else if (idx >= `MDIR_IDX_ROUTE0 && idx < `MDIR_IDX_TPEND0) begin
          route_q[idx[1:0] - 2'h2] <= (route_q[idx[1:0] - 2'h2] & ~wmsk_s)
            | wsrc;
        end else if (idx == `MDIR_IDX_MOD_POL) begin
          mod_pol_q <= (mod_pol_q & ~wmsk_m) | wmod;
        end else if (idx == `MDIR_IDX_MOD_NONLATCH) begin
          mod_nonlatch_q <= (mod_nonlatch_q & ~wmsk_m) | wmod;
        end else if (idx == `MDIR_IDX_MOD_DETECT_LO) begin
          mod_detect_q <= (mod_detect_q & ~wmask[2*NMOD-1:0])
            | wd[2*NMOD-1:0];
        end else if (idx == `MDIR_IDX_MOD_ENABLE) begin
          mod_enable_q <= (mod_enable_q & ~wmsk_m) | wmod;
        end else if (idx == `MDIR_IDX_EXT_IN_POL) begin
          ext_in_pol_q <= (ext_in_pol_q & ~wmask[1:0]) | wd[1:0];
        end else if (idx == `MDIR_IDX_EXT_OUT_POL) begin
          ext_out_pol_q <= (ext_out_pol_q & ~wmask[1:0]) | wd[1:0];
        end else if (idx == `MDIR_IDX_EXT_OUT_DRV) begin
          ext_out_drv_q <= (ext_out_drv_q & ~wmask[1:0]) | wd[1:0];
        end
      end
    end
  end
  // ****************************************
  // destination outputs
  // ****************************************
  wire [3:0] dst = {|tpend3, |tpend2, |tpend1, |tpend0};
  // polarity 0: active low, so open-collector pulls low on interrupt
  wire e0 = dst[`MDIR_DST_EXT0] ~^ ext_out_pol_q[0];
  wire e1 = dst[`MDIR_DST_EXT1] ~^ ext_out_pol_q[1];
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      core_line_zero <= 1'b0;
      core_line_one <= 1'b0;
      external_output_zero <= 1'b0;
      external_output_zero_oe <= 1'b0;
      external_output_one <= 1'b0;
      external_output_one_oe <= 1'b0;
    end else begin
      core_line_zero <= dst[`MDIR_DST_CORE0];
      core_line_one <= dst[`MDIR_DST_CORE1];
      external_output_zero <= e0;
      external_output_one <= e1;
      // drive kind 1: drive only while value is low
      external_output_zero_oe <= ~ext_out_drv_q[0] | ~e0;
      external_output_one_oe <= ~ext_out_drv_q[1] | ~e1;
    end
  end
endmodule
`default_nettype wire

// ### mdir_router_bench.sv
// self-checking bench for the interrupt router
`timescale 1ns/1ps
`default_nettype none
module mdir_router_bench;
  logic clk_sys, rst_n, avs_read, avs_write;
  logic [6:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, rdv;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, core_line_zero, core_line_one;
  wire eo0, eo0_oe, eo1, eo1_oe, pin0, pin1;
  logic [10:0] port_module_irq;
  logic external_input_zero, external_input_one;
  logic [23:3] block_irq;
  int n_mismatch = 0;
  int compares = 0;
  mdir_router dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_module_irq(port_module_irq),
    .external_input_zero(external_input_zero),
    .external_input_one(external_input_one), .block_irq(block_irq),
    .core_line_zero(core_line_zero), .core_line_one(core_line_one),
    .external_output_zero(eo0), .external_output_zero_oe(eo0_oe),
    .external_output_one(eo1), .external_output_one_oe(eo1_oe));
  mdir_wire_model wire0_u (.value(eo0), .oe(eo0_oe), .level(pin0));
  mdir_wire_model wire1_u (.value(eo1), .oe(eo1_oe), .level(pin1));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic conclude;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [4:0] i, input logic [31:0] d);
    avs_address <= {i, 2'b00};
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [4:0] i, input logic [31:0] d);
    acc(1'b1, i, d);
  endtask
  task automatic rd(input logic [4:0] i, input logic [31:0] e);
    acc(1'b0, i, 32'h0);
    chk(rdv, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  initial begin
    #250000;
    n_mismatch++;
    conclude();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, external_input_zero, external_input_one} = 4'h0;
    avs_address = 7'h00;
    avs_byteenable = 4'hf;
    avs_writedata = 32'h0;
    port_module_irq = 11'h000;
    block_irq = 21'h000000;
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    wr(5'h1a, 32'h1);
    block_irq <= 21'h1a5a5a;
    tick(4);
    rd(5'h00, 32'hd2d2d2);
    rd(5'h1d, 32'h0);
    wr(5'h1a, 32'h0);
    block_irq <= 21'h000000;
    tick(4);
    wr(5'h05, 32'hffffff);
    rd(5'h05, 32'h0);
    wr(5'h08, 32'h0f0f0f);
    wr(5'h07, 32'h00ff00);
    rd(5'h06, 32'h0f000f);
    wr(5'h07, 32'hffffff);
    wr(5'h08, 32'h10);
    for (int k = 0; k < 4; k++) begin
      wr(5'h02, {22'h0, k[1:0], 8'h00});
      wr(5'h05, 32'h10);
      block_irq[4] <= 1'b1;
      tick(3);
      rd(5'h09, (k != 2) ? 32'h10 : 32'h0);
      wr(5'h05, 32'h10);
      rd(5'h05, (k == 0) ? 32'h10 : 32'h0);
      block_irq[4] <= 1'b0;
      tick(3);
      rd(5'h05, (k != 3) ? 32'h10 : 32'h0);
    end
    wr(5'h05, 32'h10);
    wr(5'h07, 32'h10);
    wr(5'h02, 32'h0);
    wr(5'h08, 32'h08);
    wr(5'h0a, 32'h08);
    block_irq[3] <= 1'b1;
    tick(4);
    chk({30'h0, core_line_zero, core_line_one}, 32'h2);
    rd(5'h0e, 32'h08);
    rd(5'h0f, 32'h0);
    block_irq[3] <= 1'b0;
    wr(5'h05, 32'h08);
    tick(3);
    chk({30'h0, core_line_zero, core_line_one}, 32'h0);
    wr(5'h01, 32'h20);
    wr(5'h08, 32'h20);
    wr(5'h0b, 32'h20);
    block_irq[5] <= 1'b1;
    tick(4);
    chk({30'h0, core_line_zero, core_line_one}, 32'h1);
    block_irq[5] <= 1'b0;
    tick(4);
    chk({30'h0, core_line_zero, core_line_one}, 32'h0);
    wr(5'h05, 32'hffffff);
    wr(5'h04, 32'h40);
    tick(2);
    rd(5'h05, 32'h40);
    wr(5'h05, 32'h40);
    wr(5'h12, 32'h1);
    wr(5'h18, 32'h1);
    tick(4);
    rd(5'h19, 32'h1);
    rd(5'h00, 32'h1);
    wr(5'h12, 32'h0);
    wr(5'h17, 32'h1);
    tick(3);
    rd(5'h00, 32'h0);
    wr(5'h08, 32'h80);
    wr(5'h0c, 32'h80);
    wr(5'h0d, 32'h80);
    wr(5'h1b, 32'h2);
    wr(5'h1c, 32'h1);
    tick(3);
    chk({29'h0, pin0, eo1, eo1_oe}, 32'h5);
    block_irq[7] <= 1'b1;
    tick(5);
    chk({29'h0, pin0, eo1, eo1_oe}, 32'h3);
    conclude();
  end
endmodule
`default_nettype wire

// ### mdir_router_props.sv
// port checker for the interrupt router
`timescale 1ns/1ps
`default_nettype none
module mdir_router_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  // destinations
  input wire logic core_line_zero,
  input wire logic core_line_one,
  input wire logic external_output_zero_oe,
  input wire logic external_output_one_oe
);
  wire req = avs_read || avs_write;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wait_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered one cycle later");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  idle_quiet_a: assert property (!req |=> avs_waitrequest)
    else $error("answer without a request");
  answer_cause_a: assert property ($fell(avs_waitrequest) |-> $past(req))
    else $error("waitrequest fell with no request before");
  reset_wait_a: assert property ($rose(rst_n) |-> avs_waitrequest)
    else $error("waitrequest low right after reset");
  reset_quiet_a: assert property ($rose(rst_n) |-> !core_line_zero &&
    !core_line_one && !external_output_zero_oe && !external_output_one_oe)
    else $error("destination active right after reset");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  read_exact_a: assert property (avs_read && avs_waitrequest |=>
    !avs_waitrequest ##1 avs_waitrequest)
    else $error("read answer not exactly one cycle");
  cover property (avs_read && !avs_waitrequest);
  cover property ($rose(core_line_zero));
  cover property ($rose(external_output_zero_oe));
endmodule
bind mdir_router mdir_router_props props_u (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata),
  .core_line_zero(core_line_zero),
  .core_line_one(core_line_one),
  .external_output_zero_oe(external_output_zero_oe),
  .external_output_one_oe(external_output_one_oe)
);
`default_nettype wire

// ### mdir_wire_model.sv
// board wire with pull-up behind an external interrupt output
`timescale 1ns/1ps
`default_nettype none
module mdir_wire_model (
  // driver side
  input wire logic value,
  input wire logic oe,
  // resolved wire
  output logic level
);
  // released wire floats up to the pull-up
  assign level = oe ? value : 1'b1;
endmodule
`default_nettype wire
